// ===== hw/dmac_pkg.sv
// Purpose: shared constants, opcodes and helpers of the mac unit
// Assumes: opcode encoding is local to the issue logic of the core
// Notes:   all result arithmetic is two's complement

package dmac_pkg;

  typedef enum logic [3:0] {
    OP_WORD_MULTIPLY             = 4'h0,
    OP_UNSIGNED_LONG_MULTIPLY    = 4'h1,
    OP_SIGNED_LONG_MULTIPLY      = 4'h2,
    OP_WORD_MULTIPLY_ADD         = 4'h3,
    OP_LONG_MULTIPLY_ADD         = 4'h4,
    OP_WORD_MULTIPLY_SUBTRACT    = 4'h5,
    OP_LONG_MULTIPLY_SUBTRACT    = 4'h6,
    OP_HALFWORD_DUAL_MAC         = 4'h7,
    OP_HALFWORD_DUAL_MAC_LONG    = 4'h8,
    OP_COMPLEX_HALFWORD_MULTIPLY = 4'h9,
    OP_COMPLEX_HALFWORD_MAC      = 4'ha,
    OP_COMPLEX_ADD_SUBTRACT      = 4'hb,
    OP_COMPLEX_BUTTERFLY_SCALED  = 4'hc
  } dmac_op_type;

  localparam int          DMAC_WORD_W       = 32;
  localparam int          DMAC_HALF_W       = 16;
  localparam int          DMAC_ACC_W        = 66;
  localparam int          DMAC_FFT_SHIFT    = 15;
  localparam int          DMAC_MUL_STAGES   = 1;
  localparam logic [31:0] DMAC_RESULT_RESET = 32'h0000_0000;
  // per halfword product: which half of each operand feeds it
  // index 0 upper*upper, 1 lower*lower, 2 upper*lower, 3 lower*upper
  localparam logic [3:0]  DMAC_HALF_A_HI    = 4'h5;
  localparam logic [3:0]  DMAC_HALF_B_HI    = 4'h9;

  function automatic logic dmac_known(input dmac_op_type op);
    return op <= OP_COMPLEX_BUTTERFLY_SCALED;
  endfunction : dmac_known

  function automatic logic dmac_writes_high(input dmac_op_type op);
    return dmac_known(op) && op != OP_WORD_MULTIPLY
           && op != OP_WORD_MULTIPLY_ADD
           && op != OP_WORD_MULTIPLY_SUBTRACT
           && op != OP_HALFWORD_DUAL_MAC;
  endfunction : dmac_writes_high

  function automatic logic dmac_may_overflow(input dmac_op_type op);
    return op >= OP_WORD_MULTIPLY_ADD
           && op <= OP_COMPLEX_BUTTERFLY_SCALED;
  endfunction : dmac_may_overflow

endpackage : dmac_pkg

// ===== hw/dmac_mult.sv
// Purpose: registered signed multiplier, one stage
// Assumes: operands already sign or zero extended by the caller
// Notes:   product is full width, never truncated

`timescale 1ns/1ps

module dmac_mult #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  // operands
  input  wire logic signed [W-1:0]   a_in,
  input  wire logic signed [W-1:0]   b_in,
  // product
  output logic signed [2*W-1:0]      prod_out
);

  typedef struct packed {
    logic signed [2*W-1:0] prod;
  } dmac_mult_state_type;

  dmac_mult_state_type st_reg;
  dmac_mult_state_type st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.prod = a_in * b_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prod_out = st_reg.prod;

endmodule : dmac_mult

// ===== hw/dmac_hazard.sv
// Purpose: tracks result registers still owed by ops in flight
// Assumes: every op writes the low result, some also the high one
// Notes:   stall is combinational toward the issue stage

`timescale 1ns/1ps

module dmac_hazard #(
  parameter int DEPTH = 1
) (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // issue of an extended op
  input  wire logic issue_valid_in,
  input  wire logic issue_high_in,
  // reads by ordinary instructions
  input  wire logic rd_low_in,
  input  wire logic rd_high_in,
  // status
  output logic      stall_out,
  output logic      pend_low_out,
  output logic      pend_high_out
);

  typedef struct packed {
    logic [DEPTH-1:0] low;
    logic [DEPTH-1:0] high;
  } dmac_hazard_state_type;

  dmac_hazard_state_type st_reg;
  dmac_hazard_state_type st_next;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      if (i == 0) begin : g_first
        assign st_next.low[i]  = issue_valid_in;
        assign st_next.high[i] = issue_valid_in & issue_high_in;
      end else begin : g_rest
        assign st_next.low[i]  = st_reg.low[i-1];
        assign st_next.high[i] = st_reg.high[i-1];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pend_low_out  = |st_reg.low;
  assign pend_high_out = |st_reg.high;
  assign stall_out     = (rd_low_in & pend_low_out)
                         | (rd_high_in & pend_high_out);

endmodule : dmac_hazard

// ===== hw/dmac_unit.sv
// Purpose: multiply-accumulate unit for the extended dsp ops
// Assumes: issue side delivers both operand register values
// Notes:   results appear two edges after issue
//
// How it works
// - single results go to low register, double ones to high/low pair
// - condition flags are never written by any extended op
// - word multiply puts low product word into low register
// - long multiplies store full unsigned or signed product in pair
// - word multiply-add adds signed product to low register
// - long multiply-add adds signed product to 64-bit pair
// - word multiply-subtract subtracts signed product from low register
// - long multiply-subtract subtracts signed product from 64-bit pair
// - halfword dual mac adds both halfword products to low register
// - long halfword dual mac adds both halfword products to the pair
// - complex multiply: high gets real part, low gets cross sum
// - complex mac adds real part to high register
// - complex add/subtract: halves plus old pair high, minus low
// - butterfly: like add/subtract, old pair shifted right fifteen first
// - one op issues per cycle, no back-pressure on issue
// - ordinary readers wait only while a result is still pending
// - ops from word multiply-add to butterfly raise overflow exception while ovf_disable_in is low

`timescale 1ns/1ps

module dmac_unit
  import dmac_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // issue of an extended op
  input  wire logic        issue_valid_in,
  input  wire dmac_op_type issue_op_in,
  input  wire logic [31:0] dst_opnd_in,
  input  wire logic [31:0] src_opnd_in,
  // ordinary register file access to the result registers
  input  wire logic        rd_low_in,
  input  wire logic        rd_high_in,
  input  wire logic        wr_low_in,
  input  wire logic        wr_high_in,
  input  wire logic [31:0] wr_data_in,
  // overflow exception enable, high disables
  input  wire logic        ovf_disable_in,
  // results and status
  output logic [31:0]      low_result_out,
  output logic [31:0]      high_result_out,
  output logic             result_valid_out,
  output logic             stall_out,
  output logic             overflow_exc_out,
  output logic             cond_flags_we_out
);

  typedef struct packed {
    logic        s1_valid;
    dmac_op_type s1_op;
    logic [31:0] s1_dst;
    logic [31:0] low;
    logic [31:0] high;
    logic        done;
    logic        ovf;
  } dmac_unit_state_type;

  dmac_unit_state_type st_reg;
  dmac_unit_state_type st_next;

  logic signed [65:0] word_prod_w;
  logic signed [31:0] half_prod_w [4];
  logic signed [32:0] word_a_w;
  logic signed [32:0] word_b_w;
  logic               sext_w;

  function automatic logic signed [65:0] sx32(input logic [31:0] v);
    return {{34{v[31]}}, v};
  endfunction : sx32

  function automatic logic signed [65:0] sx16(input logic [15:0] v);
    return {{50{v[15]}}, v};
  endfunction : sx16

  function automatic logic fits(input logic signed [65:0] v,
                                input int w);
    logic signed [65:0] t;
    t = v >>> (w - 1);
    return (t == '0) || (t == '1);
  endfunction : fits

  // word product, zero extension only for the unsigned long form
  assign sext_w   = issue_op_in != OP_UNSIGNED_LONG_MULTIPLY;
  assign word_a_w = {sext_w & dst_opnd_in[31], dst_opnd_in};
  assign word_b_w = {sext_w & src_opnd_in[31], src_opnd_in};

  dmac_mult #(
    .W (DMAC_WORD_W + 1)
  ) u_word_mult (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .a_in       (word_a_w),
    .b_in       (word_b_w),
    .prod_out   (word_prod_w)
  );

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_half
      logic signed [15:0] ha_w;
      logic signed [15:0] hb_w;
      assign ha_w = DMAC_HALF_A_HI[i] ? dst_opnd_in[31:16]
                                      : dst_opnd_in[15:0];
      assign hb_w = DMAC_HALF_B_HI[i] ? src_opnd_in[31:16]
                                      : src_opnd_in[15:0];
      dmac_mult #(
        .W (DMAC_HALF_W)
      ) u_half_mult (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .a_in       (ha_w),
        .b_in       (hb_w),
        .prod_out   (half_prod_w[i])
      );
    end
  endgenerate

  dmac_hazard #(
    .DEPTH (DMAC_MUL_STAGES)
  ) u_hazard (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .issue_valid_in (issue_valid_in & dmac_known(issue_op_in)),
    .issue_high_in  (dmac_writes_high(issue_op_in)),
    .rd_low_in      (rd_low_in),
    .rd_high_in     (rd_high_in),
    .stall_out      (stall_out),
    .pend_low_out   (),
    .pend_high_out  ()
  );

  logic signed [65:0] acc_v;
  logic signed [65:0] re_v;
  logic signed [65:0] im_v;
  logic signed [65:0] hh_v;
  logic signed [65:0] ll_v;
  logic signed [65:0] hl_v;
  logic signed [65:0] lh_v;
  logic signed [65:0] pair_v;
  logic signed [31:0] old_hi_v;
  logic signed [31:0] old_lo_v;
  logic signed [65:0] bf_v [4];
  logic               ovf_v;

  always_comb begin
    st_next  = st_reg;
    hh_v     = sx32(half_prod_w[0]);
    ll_v     = sx32(half_prod_w[1]);
    hl_v     = sx32(half_prod_w[2]);
    lh_v     = sx32(half_prod_w[3]);
    pair_v   = {{2{st_reg.high[31]}}, st_reg.high, st_reg.low};
    acc_v    = '0;
    re_v     = '0;
    im_v     = '0;
    ovf_v    = 1'b0;
    old_hi_v = st_reg.high;
    old_lo_v = st_reg.low;
    if (st_reg.s1_op == OP_COMPLEX_BUTTERFLY_SCALED) begin
      old_hi_v = $signed(st_reg.high) >>> DMAC_FFT_SHIFT;
      old_lo_v = $signed(st_reg.low) >>> DMAC_FFT_SHIFT;
    end
    // source operand never enters these four sums
    bf_v[0] = sx16(st_reg.s1_dst[31:16]) + sx16(old_hi_v[15:0]);
    bf_v[1] = sx16(st_reg.s1_dst[15:0]) + sx16(old_lo_v[15:0]);
    bf_v[2] = sx16(st_reg.s1_dst[31:16]) - sx16(old_hi_v[15:0]);
    bf_v[3] = sx16(st_reg.s1_dst[15:0]) - sx16(old_lo_v[15:0]);

    // plain register file writes, the unit's completion wins below
    if (wr_low_in) begin
      st_next.low = wr_data_in;
    end
    if (wr_high_in) begin
      st_next.high = wr_data_in;
    end

    // issue stage, accepted every cycle
    st_next.s1_valid = issue_valid_in & dmac_known(issue_op_in);
    st_next.s1_op    = issue_op_in;
    st_next.s1_dst   = dst_opnd_in;

    if (st_reg.s1_valid) begin
      case (st_reg.s1_op)
        OP_WORD_MULTIPLY: begin
          st_next.low = word_prod_w[31:0];
        end
        OP_UNSIGNED_LONG_MULTIPLY, OP_SIGNED_LONG_MULTIPLY: begin
          {st_next.high, st_next.low} = word_prod_w[63:0];
        end
        OP_WORD_MULTIPLY_ADD: begin
          acc_v       = sx32(st_reg.low) + word_prod_w;
          st_next.low = acc_v[31:0];
          ovf_v       = !fits(acc_v, DMAC_WORD_W);
        end
        OP_LONG_MULTIPLY_ADD: begin
          acc_v = pair_v + word_prod_w;
          {st_next.high, st_next.low} = acc_v[63:0];
          ovf_v = !fits(acc_v, 2 * DMAC_WORD_W);
        end
        OP_WORD_MULTIPLY_SUBTRACT: begin
          acc_v       = sx32(st_reg.low) - word_prod_w;
          st_next.low = acc_v[31:0];
          ovf_v       = !fits(acc_v, DMAC_WORD_W);
        end
        OP_LONG_MULTIPLY_SUBTRACT: begin
          acc_v = pair_v - word_prod_w;
          {st_next.high, st_next.low} = acc_v[63:0];
          ovf_v = !fits(acc_v, 2 * DMAC_WORD_W);
        end
        OP_HALFWORD_DUAL_MAC: begin
          acc_v       = sx32(st_reg.low) + hh_v + ll_v;
          st_next.low = acc_v[31:0];
          ovf_v       = !fits(acc_v, DMAC_WORD_W);
        end
        OP_HALFWORD_DUAL_MAC_LONG: begin
          acc_v = pair_v + hh_v + ll_v;
          {st_next.high, st_next.low} = acc_v[63:0];
          ovf_v = !fits(acc_v, 2 * DMAC_WORD_W);
        end
        OP_COMPLEX_HALFWORD_MULTIPLY: begin
          re_v         = hh_v - ll_v;
          im_v         = hl_v + lh_v;
          st_next.high = re_v[31:0];
          st_next.low  = im_v[31:0];
          ovf_v = !fits(re_v, DMAC_WORD_W) || !fits(im_v, DMAC_WORD_W);
        end
        OP_COMPLEX_HALFWORD_MAC: begin
          re_v         = sx32(st_reg.high) + hh_v - ll_v;
          im_v         = sx32(st_reg.low) + hl_v + lh_v;
          st_next.high = re_v[31:0];
          st_next.low  = im_v[31:0];
          ovf_v = !fits(re_v, DMAC_WORD_W) || !fits(im_v, DMAC_WORD_W);
        end
        OP_COMPLEX_ADD_SUBTRACT, OP_COMPLEX_BUTTERFLY_SCALED: begin
          st_next.high = {bf_v[0][15:0], bf_v[1][15:0]};
          st_next.low  = {bf_v[2][15:0], bf_v[3][15:0]};
          ovf_v = !fits(bf_v[0], DMAC_HALF_W)
                  || !fits(bf_v[1], DMAC_HALF_W)
                  || !fits(bf_v[2], DMAC_HALF_W)
                  || !fits(bf_v[3], DMAC_HALF_W);
        end
        default: begin
          ovf_v = 1'b0;
        end
      endcase
    end
    st_next.done = st_reg.s1_valid;
    st_next.ovf  = st_reg.s1_valid && ovf_v && !ovf_disable_in
                   && dmac_may_overflow(st_reg.s1_op);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg      <= '0;
      st_reg.low  <= DMAC_RESULT_RESET;
      st_reg.high <= DMAC_RESULT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign low_result_out    = st_reg.low;
  assign high_result_out   = st_reg.high;
  assign result_valid_out  = st_reg.done;
  assign overflow_exc_out  = st_reg.ovf;
  assign cond_flags_we_out = 1'b0;

  // checking helpers
  logic [31:0] chk_prod32;
  logic [63:0] chk_uprod;
  logic [15:0] chk_dhi;
  logic [15:0] chk_hi_lo16;
  assign chk_prod32  = dst_opnd_in * src_opnd_in;
  assign chk_uprod   = {32'h0000_0000, dst_opnd_in}
                       * {32'h0000_0000, src_opnd_in};
  assign chk_dhi     = dst_opnd_in[31:16];
  assign chk_hi_lo16 = high_result_out[15:0];

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence seq_issue(dmac_op_type op);
    issue_valid_in && issue_op_in == op;
  endsequence

  sequence seq_quiet;
    !issue_valid_in && !st_reg.s1_valid;
  endsequence

  AST_WORD_MUL: assert property (
    seq_issue(OP_WORD_MULTIPLY) |-> ##2
      low_result_out == $past(chk_prod32, 2))
    else $error("word multiply low result wrong");

  AST_ULONG_MUL: assert property (
    seq_issue(OP_UNSIGNED_LONG_MULTIPLY) |-> ##2
      {high_result_out, low_result_out} == $past(chk_uprod, 2))
    else $error("unsigned long product wrong");

  AST_WORD_MAC: assert property (
    seq_issue(OP_WORD_MULTIPLY_ADD) |-> ##2
      low_result_out == $past(low_result_out, 1) + $past(chk_prod32, 2))
    else $error("word multiply-add sum wrong");

  AST_WORD_MSUB: assert property (
    seq_issue(OP_WORD_MULTIPLY_SUBTRACT) |-> ##2
      low_result_out == $past(low_result_out, 1) - $past(chk_prod32, 2))
    else $error("word multiply-subtract difference wrong");

  AST_CSUM_HI: assert property (
    seq_issue(OP_COMPLEX_ADD_SUBTRACT) |-> ##2
      high_result_out[31:16] == $past(chk_dhi, 2) + $past(chk_hi_lo16, 1))
    else $error("complex sum upper half wrong");

  AST_NO_FLAGS: assert property (
    !cond_flags_we_out)
    else $error("condition flags written");

  AST_STALL_PENDING: assert property (
    st_reg.s1_valid && rd_low_in |-> stall_out)
    else $error("read of pending low result not stalled");

  AST_NO_STALL_IDLE: assert property (
    seq_quiet |-> !stall_out ##1 !stall_out)
    else $error("stall with nothing in flight");

  AST_OVF_MUTED: assert property (
    ovf_disable_in ##1 1'b1 |-> !overflow_exc_out)
    else $error("overflow exception while disabled");

  AST_MUL_NO_OVF: assert property (
    seq_issue(OP_SIGNED_LONG_MULTIPLY) |-> ##2 !overflow_exc_out)
    else $error("plain multiply raised overflow");

  AST_DONE_TIMING: assert property (
    issue_valid_in && dmac_known(issue_op_in) |-> ##2 result_valid_out)
    else $error("result not valid two edges after issue");

endmodule : dmac_unit

// ===== verification/dmac_core_model.sv
// Purpose: issue side of the core that feeds the mac unit
// Assumes: requests change just after a rising edge
// Notes:   idle operand and data lines show the inverse of the last value, but the source line shows ~s after complex add/subtract and butterfly

`timescale 1ns/1ps

module dmac_core_model
  import dmac_pkg::*;
(
  // clock
  input  wire logic   clk_sys_in,
  // issue of extended ops
  output dmac_op_type issue_op_out,
  output logic        issue_valid_out,
  output logic [31:0] dst_opnd_out,
  output logic [31:0] src_opnd_out,
  // ordinary writes of the result registers
  output logic        wr_low_out,
  output logic        wr_high_out,
  output logic [31:0] wr_data_out
);

  initial begin
    issue_valid_out = 1'b0;
    issue_op_out    = OP_WORD_MULTIPLY;
    dst_opnd_out    = 32'h0000_0000;
    src_opnd_out    = 32'hffff_ffff;
    wr_low_out      = 1'b0;
    wr_high_out     = 1'b0;
    wr_data_out     = 32'h0000_0000;
  end

  // one op per edge; hold keeps valid up for a following op
  task automatic issue(input dmac_op_type op, input logic [31:0] d,
                       input logic [31:0] s, input bit hold);
    @(posedge clk_sys_in);
    issue_valid_out <= 1'b1;
    issue_op_out    <= op;
    dst_opnd_out    <= d;
    if (op == OP_COMPLEX_ADD_SUBTRACT ||
        op == OP_COMPLEX_BUTTERFLY_SCALED) begin
      src_opnd_out <= d;
    end else begin
      src_opnd_out <= s;
    end
    if (!hold) begin
      @(posedge clk_sys_in);
      issue_valid_out <= 1'b0;
      dst_opnd_out    <= ~d;
      src_opnd_out    <= ~s;
    end
  endtask : issue

  task automatic write_result(input bit high, input logic [31:0] v);
    @(posedge clk_sys_in);
    wr_low_out  <= !high;
    wr_high_out <= high;
    wr_data_out <= v;
    @(posedge clk_sys_in);
    wr_low_out  <= 1'b0;
    wr_high_out <= 1'b0;
    wr_data_out <= ~v;
  endtask : write_result

endmodule : dmac_core_model

// ===== verification/tb_dmac_unit.sv
// Purpose: self-checking bench of the mac unit against an integer model
// Assumes: results seen two edges after the issue edge
// Notes:   overflow judged for ops 3 to 12 from the exact sums of the model, plain multiplies expect none

`timescale 1ns/1ps

module tb_dmac_unit;
  import dmac_pkg::*;

  logic        clk_sys_in;
  logic        rst_in;
  logic        rd_low_in;
  logic        rd_high_in;
  logic        ovf_disable_in;
  dmac_op_type issue_op;
  logic        issue_valid;
  logic [31:0] dst_opnd;
  logic [31:0] src_opnd;
  logic        wr_low;
  logic        wr_high;
  logic [31:0] wr_data;
  logic [31:0] low_result_out;
  logic [31:0] high_result_out;
  logic        result_valid_out;
  logic        stall_out;
  logic        overflow_exc_out;
  logic        cond_flags_we_out;
  int          mismatches;
  int          n_compared;
  logic [31:0] elo;
  logic [31:0] ehi;
  logic        eovf;
  logic [31:0] d;
  logic [31:0] s;

  dmac_core_model u_dmac_core_model (
    .clk_sys_in      (clk_sys_in),
    .issue_op_out    (issue_op),
    .issue_valid_out (issue_valid),
    .dst_opnd_out    (dst_opnd),
    .src_opnd_out    (src_opnd),
    .wr_low_out      (wr_low),
    .wr_high_out     (wr_high),
    .wr_data_out     (wr_data)
  );

  dmac_unit u_dmac_unit (
    .clk_sys_in        (clk_sys_in),
    .rst_in            (rst_in),
    .issue_valid_in    (issue_valid),
    .issue_op_in       (issue_op),
    .dst_opnd_in       (dst_opnd),
    .src_opnd_in       (src_opnd),
    .rd_low_in         (rd_low_in),
    .rd_high_in        (rd_high_in),
    .wr_low_in         (wr_low),
    .wr_high_in        (wr_high),
    .wr_data_in        (wr_data),
    .ovf_disable_in    (ovf_disable_in),
    .low_result_out    (low_result_out),
    .high_result_out   (high_result_out),
    .result_valid_out  (result_valid_out),
    .stall_out         (stall_out),
    .overflow_exc_out  (overflow_exc_out),
    .cond_flags_we_out (cond_flags_we_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic complete_run;
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic model_op(input int op, input logic [31:0] d,
                          input logic [31:0] s);
    longint      p;
    longint      acc;
    longint      q;
    longint      r;
    int          dh;
    int          dl;
    int          sh;
    int          sl;
    int          t;
    int          hv [4];
    logic [15:0] a;
    logic [15:0] b;
    dh = int'(signed'(d[31:16]));
    dl = int'(signed'(d[15:0]));
    sh = int'(signed'(s[31:16]));
    sl = int'(signed'(s[15:0]));
    p = longint'(signed'(d)) * longint'(signed'(s));
    eovf = 1'b0;
    case (op)
      0: elo = d * s;
      1: {ehi, elo} = {32'h0, d} * {32'h0, s};
      2: {ehi, elo} = p;
      3, 5, 7: begin
        acc = longint'(signed'(elo)) + ((op == 3) ? p : (op == 5) ? -p
              : longint'(dh * sh) + longint'(dl * sl));
        eovf = acc != longint'(int'(acc));
        elo = acc[31:0];
      end
      4, 6, 8: begin
        q = (op == 4) ? p : (op == 6) ? -p
            : longint'(dh * sh) + longint'(dl * sl);
        acc = longint'({ehi, elo});
        r = acc + q;
        // exact sum leaves 64 bits when signs agree and the result flips
        eovf = acc[63] == q[63] && r[63] != acc[63];
        {ehi, elo} = r;
      end
      9, 10: begin
        acc = longint'(dh * sh) - longint'(dl * sl);
        q = longint'(dh * sl) + longint'(dl * sh);
        if (op == 10) begin
          acc = acc + longint'(signed'(ehi));
          q = q + longint'(signed'(elo));
        end
        eovf = acc != longint'(int'(acc)) || q != longint'(int'(q));
        ehi = acc[31:0];
        elo = q[31:0];
      end
      default: begin
        a = ehi[15:0];
        b = elo[15:0];
        if (op == 12) begin
          t = int'(signed'(ehi)) >>> 15;
          a = t[15:0];
          t = int'(signed'(elo)) >>> 15;
          b = t[15:0];
        end
        hv[0] = dh + int'(signed'(a));
        hv[1] = dl + int'(signed'(b));
        hv[2] = dh - int'(signed'(a));
        hv[3] = dl - int'(signed'(b));
        foreach (hv[j]) begin
          eovf = eovf | (hv[j] != int'(shortint'(hv[j])));
        end
        ehi = {hv[0][15:0], hv[1][15:0]};
        elo = {hv[2][15:0], hv[3][15:0]};
      end
    endcase
  endtask : model_op

  task automatic preset(input logic [31:0] lo, input logic [31:0] hi);
    u_dmac_core_model.write_result(1'b0, lo);
    u_dmac_core_model.write_result(1'b1, hi);
    #1;
    check({high_result_out, low_result_out}, {hi, lo}, "preset");
    elo = lo;
    ehi = hi;
  endtask : preset

  // waits for the completion pulse of the last op, then compares
  task automatic await_result;
    bit got;
    got = 1'b0;
    for (int i = 0; i < 6 && !got; i++) begin
      @(posedge clk_sys_in);
      rd_low_in  <= 1'b0;
      rd_high_in <= 1'b0;
      #1;
      got = result_valid_out === 1'b1;
    end
    check(got, 1'b1, "result pulse");
    check(low_result_out, elo, "low");
    check(high_result_out, ehi, "high");
    check(overflow_exc_out, eovf && !ovf_disable_in, "overflow");
    check(cond_flags_we_out, 1'b0, "flags");
  endtask : await_result

  task automatic run_op(input int op, input logic dis, input logic rl,
                        input logic rh);
    logic hi_op;
    hi_op = !(op == 0 || op == 3 || op == 5 || op == 7);
    @(posedge clk_sys_in);
    ovf_disable_in <= dis;
    u_dmac_core_model.issue(dmac_op_type'(op[3:0]), d, s, 1'b0);
    rd_low_in  <= rl;
    rd_high_in <= rh;
    #1;
    check(stall_out, rl | (rh & hi_op), "stall");
    model_op(op, d, s);
    await_result();
  endtask : run_op

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  initial begin
    rst_in         = 1'b1;
    rd_low_in      = 1'b0;
    rd_high_in     = 1'b0;
    ovf_disable_in = 1'b1;
    mismatches     = 0;
    n_compared     = 0;
    void'($urandom(88559));
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    check({high_result_out, low_result_out}, 64'h0, "reset value");
    check({result_valid_out, stall_out, overflow_exc_out}, 3'b000,
          "reset pulses");
    for (int op = 0; op < 13; op++) begin
      for (int it = 0; it < 4; it++) begin
        if (it == 0) preset(32'h7fff_ffff, $urandom);
        else if (it == 2) preset($urandom, $urandom);
        d = (it == 0) ? 32'h8000_0000 : $urandom;
        s = (it < 2) ? 32'h8000_0000 : $urandom;
        run_op(op, (it == 0) ? 1'b0 : 1'($urandom), 1'($urandom),
               1'($urandom));
      end
    end
    // accumulating ops issued back to back must chain
    @(posedge clk_sys_in);
    ovf_disable_in <= 1'b1;
    preset($urandom, $urandom);
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      s = $urandom;
      u_dmac_core_model.issue(dmac_op_type'(4'(3 + k)), d, s, k != 5);
      model_op(3 + k, d, s);
    end
    await_result();
    // an unknown opcode leaves everything alone
    u_dmac_core_model.issue(dmac_op_type'(4'hd), $urandom, $urandom, 1'b0);
    repeat (3) begin
      @(posedge clk_sys_in);
      #1;
      check(result_valid_out, 1'b0, "unknown op pulse");
    end
    check({high_result_out, low_result_out}, {ehi, elo}, "unknown op");
    complete_run();
  end

endmodule : tb_dmac_unit
